// ---- rtl/charger_consts.svh ----
// Constants for the charger mode control block: offsets, bits, resets,
// strap defaults and timing. Assumes a 50 MHz core clock.
`ifndef CHARGER_CONSTS_SVH
`define CHARGER_CONSTS_SVH

`define CLK_PERIOD_NS    20
`define STRAP_SETTLE_US  40
`define STRAP_SETTLE_CYC (`STRAP_SETTLE_US * 1000 / `CLK_PERIOD_NS)
`define ENTRY_DEBOUNCE_MS 1
`define ENTRY_CYC  (`ENTRY_DEBOUNCE_MS * 1000000 / `CLK_PERIOD_NS)
`define EXIT_SHORT_MS 20
`define EXIT_LONG_MS  200
`define EXIT_SHORT_CYC (`EXIT_SHORT_MS * 1000000 / `CLK_PERIOD_NS)
`define EXIT_LONG_CYC  (`EXIT_LONG_MS * 1000000 / `CLK_PERIOD_NS)
`define SAFETY_HRS 12
`define SAFETY_CYC \
	(64'd`SAFETY_HRS * 64'd3600 * 64'd1000000000 / 64'd`CLK_PERIOD_NS)
`define LS_MIN_ON_NS 400
`define LS_MIN_ON_CYC ((`LS_MIN_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_CHARGE   8'h14
`define ADDR_UPPER    8'h15
`define ADDR_OPT_A    8'h3c
`define ADDR_OPT_B    8'h3d
`define ADDR_LOWER    8'h3e
`define ADDR_ADP_LIM  8'h3f
`define ADDR_OPT_C    8'h4c

`define OPT_A_SYSTEM_POWER_MONITOR_BIT  3
`define OPT_A_FREQ_LSB  8
`define OPT_C_HOST_BIT  7
`define OPT_C_SHIP_BIT  10
`define OPT_C_TERM_BIT  13

`define OPT_A_RESET   16'h0000
`define OPT_B_RESET   16'h0000
`define OPT_C_RESET   16'h0080
`define CHARGE_NO_BFET 16'h0020
`define CHARGE_AUTO    16'h01f4
`define ILIM_HIGH      16'h00bc
`define ILIM_LOW       16'h003c
`define MIN_BASE_MV    16'h1400
`define MIN_STEP_MV    16'h0a00
`define MAX_BASE_MV    16'h20d0
`define MAX_STEP_MV    16'h1068
`define MAX_ODD_MV     16'h0008
`define BAND_COUNT     5'h12

`endif

// ---- rtl/charger_pkg.sv ----
// Types and strap decode helpers for the charger mode control block.
// Assumes the constants header is on the include path.
`include "charger_consts.svh"
package charger_pkg;

	typedef enum logic [2:0] {
		AUTO_OFF,
		AUTO_WAIT,
		AUTO_CHARGE,
		AUTO_DONE,
		AUTO_EXPIRED
	} auto_state_type;

	// Three bands per cell count, 2 to 7 cells
	function automatic logic [2:0] cell_index_of(input logic [4:0] band);
		cell_index_of = 3'(band / 5'd3);
	endfunction

	function automatic logic [1:0] slot_of(input logic [4:0] band);
		slot_of = 2'(band % 5'd3);
	endfunction

	function automatic logic [15:0] upper_mv_of(input logic [4:0] band);
		logic [2:0] idx;
		idx = cell_index_of(band);
		upper_mv_of = 16'(`MAX_BASE_MV + idx * `MAX_STEP_MV
			+ (idx[0] ? `MAX_ODD_MV : 16'h0000));
	endfunction

	function automatic logic [15:0] lower_mv_of(input logic [4:0] band);
		lower_mv_of = 16'(`MIN_BASE_MV + cell_index_of(band) * `MIN_STEP_MV);
	endfunction

	function automatic logic [15:0] adp_limit_of(input logic [4:0] band);
		adp_limit_of = (slot_of(band) == 2'd2) ? `ILIM_LOW : `ILIM_HIGH;
	endfunction

endpackage

// ---- rtl/hold_timer.sv ----
// Counts cycles while a condition holds; done once held for limit cycles.
// Condition must come from the same clock domain.
`timescale 1ns/10ps
module hold_timer #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             resetn_in,
	input  wire logic             cond_in,
	input  wire logic [WIDTH-1:0] limit_in,
	output logic                  done_out
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             next_done;

	always_comb
	begin
		next_count = '0;
		if (cond_in)
			next_count = (count == limit_in) ? count : count + 1'b1;
		next_done = cond_in && (next_count == limit_in);
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			count    <= '0;
			done_out <= 1'b0;
		end
		else
		begin
			count    <= next_count;
			done_out <= next_done;
		end
	end
endmodule

// ---- rtl/strap_reader.sv ----
// Strap measurement: sources the pin current, waits for the RC to settle,
// then latches the band. Band input is already synchronised by the caller.
`timescale 1ns/10ps
`include "charger_consts.svh"
module strap_reader (
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       start_in,
	input  wire logic [4:0] band_in,
	output logic            source_en_out,
	output logic [4:0]      band_out,
	output logic            valid_out,
	output logic            done_out
);
	localparam logic [11:0] SETTLE = 12'(`STRAP_SETTLE_CYC);

	logic [11:0] count;
	logic [11:0] next_count;
	logic        next_busy;
	logic [4:0]  next_band;
	logic        next_valid;
	logic        next_done;

	always_comb
	begin
		next_busy  = source_en_out;
		next_count = count;
		next_band  = band_out;
		next_valid = valid_out;
		next_done  = 1'b0;
		if (!source_en_out)
		begin
			if (start_in)
			begin
				next_busy  = 1'b1;
				next_count = '0;
			end
		end
		else if (count == SETTLE - 12'd1)
		begin
			next_busy  = 1'b0;
			// Out-of-range readings clamp to the top band
			next_band  = (band_in >= `BAND_COUNT) ?
				`BAND_COUNT - 5'd1 : band_in;
			next_valid = 1'b1;
			next_done  = 1'b1;
		end
		else
			next_count = count + 12'd1;
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			source_en_out <= 1'b0;
			count         <= '0;
			band_out      <= '0;
			valid_out     <= 1'b0;
			done_out      <= 1'b0;
		end
		else
		begin
			source_en_out <= next_busy;
			count         <= next_count;
			band_out      <= next_band;
			valid_out     <= next_valid;
			done_out      <= next_done;
		end
	end
endmodule

// ---- rtl/charger_mode_control.sv ----
// Charger mode control: strap defaults, autonomous charging, ship mode,
// option registers and low-side minimum on-time. Registers are written by
// an SMBus engine outside; analog status pins are asynchronous.
`timescale 1ns/10ps
`include "charger_consts.svh"
module charger_mode_control #(
	parameter logic [15:0] ENTRY_CYC      = 16'(`ENTRY_CYC),
	parameter logic [23:0] EXIT_SHORT_CYC = 24'(`EXIT_SHORT_CYC),
	parameter logic [23:0] EXIT_LONG_CYC  = 24'(`EXIT_LONG_CYC),
	parameter logic [41:0] SAFETY_CYC     = 42'(`SAFETY_CYC)
) (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_write_in,
	input  wire logic        topology_select_pin_in,
	input  wire logic        adapter_present_in,
	input  wire logic        batt_below_target_in,
	input  wire logic        charge_below_term_in,
	input  wire logic        constant_voltage_loop_in,
	input  wire logic [4:0]  strap_band_in,
	input  wire logic        lowside_request_in,
	input  wire logic        zero_cross_blocking_in,
	output logic [15:0]      reg_rdata_out,
	output logic             strap_source_en_out,
	output logic             adapter_switch_gate_out,
	output logic             battery_fet_gate_out,
	output logic             charge_enable_out,
	output logic [15:0]      charge_current_cmd_out,
	output logic [15:0]      upper_sys_voltage_out,
	output logic [15:0]      lower_sys_voltage_out,
	output logic [15:0]      adapter_limit_out,
	output logic [1:0]       switch_freq_sel_out,
	output logic             throttle_alert_out,
	output logic             throttle_alert_oe_n_out,
	output logic             host_timeout_hold_out,
	output logic             autonomous_active_out,
	output logic             lowside_gate_out,
	output logic             period_stretch_out
);
	localparam logic [4:0] LS_MIN = 5'(`LS_MIN_ON_CYC);

	logic [9:0] sync1;
	logic [9:0] sync2;
	wire s_topo  = sync2[0];
	wire s_adp   = sync2[1];
	wire s_below = sync2[2];
	wire s_term  = sync2[3];
	wire s_cv    = sync2[4];
	wire [4:0] s_band = sync2[9:5];

	// Topology capture waits for the synchroniser to fill after reset
	logic [1:0] por_cnt, next_por_cnt;
	logic       topo_known, next_topo_known;
	logic       bfet_config, next_bfet_config;
	wire topo_capture = (por_cnt == 2'd2) && !topo_known;

	logic [15:0] opt_a, opt_b, opt_c, charge, upper, lower, adp_lim;
	logic [15:0] next_opt_a, next_opt_b, next_opt_c, next_charge;
	logic [15:0] next_upper, next_lower, next_adp_lim;
	logic pend_read, pend_full, pend_adp, asg, adp_prev, system_power_monitor_prev;
	logic next_pend_read, next_pend_full, next_pend_adp, next_asg;

	logic       strap_busy, strap_valid;
	logic [4:0] strap_band;
	wire strap_start = pend_read && !strap_busy;
	wire apply = (pend_full || pend_adp) && !pend_read && !strap_busy
		&& strap_valid;
	wire adp_rise  = topo_known && s_adp && !adp_prev;
	wire system_power_monitor_on   = opt_a[`OPT_A_SYSTEM_POWER_MONITOR_BIT];
	wire system_power_monitor_rise = topo_known && system_power_monitor_on && !system_power_monitor_prev && !s_adp;

	charger_pkg::auto_state_type state, next_state;
	logic entry_done, exit_done, safety_done;
	wire auto_en = topo_known && bfet_config && !opt_c[`OPT_C_HOST_BIT];
	wire entry_cond = (state == charger_pkg::AUTO_WAIT
		|| state == charger_pkg::AUTO_DONE)
		&& battery_fet_gate_out && s_below;
	wire exit_cond = (state == charger_pkg::AUTO_CHARGE) && s_term && s_cv;
	wire [23:0] exit_limit = opt_c[`OPT_C_TERM_BIT] ?
		EXIT_LONG_CYC : EXIT_SHORT_CYC;

	logic [4:0] ls_cnt, next_ls_cnt;
	logic       next_ls_gate;

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= {strap_band_in, constant_voltage_loop_in,
				charge_below_term_in, batt_below_target_in,
				adapter_present_in, topology_select_pin_in};
			sync2 <= sync1;
		end
	end

	always_comb
	begin
		next_por_cnt     = (por_cnt == 2'd3) ? por_cnt : por_cnt + 2'd1;
		next_topo_known  = topo_known || topo_capture;
		// Pin tied high means no battery FET
		next_bfet_config = topo_capture ? !s_topo : bfet_config;
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			por_cnt     <= '0;
			topo_known  <= 1'b0;
			bfet_config <= 1'b0;
		end
		else
		begin
			por_cnt     <= next_por_cnt;
			topo_known  <= next_topo_known;
			bfet_config <= next_bfet_config;
		end
	end

	strap_reader u_strap (
		.clk_in        (clk_in),
		.resetn_in     (resetn_in),
		.start_in      (strap_start),
		.band_in       (s_band),
		.source_en_out (strap_busy),
		.band_out      (strap_band),
		.valid_out     (strap_valid),
		.done_out      ()
	);

	assign strap_source_en_out = strap_busy;

	always_comb
	begin
		next_opt_a = opt_a;
		next_opt_b = opt_b;
		next_opt_c = opt_c;
		next_charge = charge;
		next_upper = upper;
		next_lower = lower;
		next_adp_lim = adp_lim;
		next_pend_read = pend_read && !strap_start;
		next_pend_full = pend_full;
		next_pend_adp = pend_adp && s_adp;
		next_asg = asg && s_adp;
		if (reg_write_in)
		begin
			case (reg_addr_in)
			`ADDR_OPT_A: next_opt_a = reg_wdata_in;
			`ADDR_OPT_B: next_opt_b = reg_wdata_in;
			`ADDR_OPT_C:
			begin
				next_opt_c = reg_wdata_in;
				// Ship may be set only with no adapter
				if (s_adp && !opt_c[`OPT_C_SHIP_BIT])
					next_opt_c[`OPT_C_SHIP_BIT] = 1'b0;
			end
			`ADDR_CHARGE:
			begin
				next_charge = reg_wdata_in;
				next_opt_c[`OPT_C_HOST_BIT] = 1'b1;
			end
			`ADDR_UPPER:
			begin
				next_upper = reg_wdata_in;
				next_opt_c[`OPT_C_HOST_BIT] = 1'b1;
			end
			`ADDR_LOWER: next_lower = reg_wdata_in;
			`ADDR_ADP_LIM: next_adp_lim = reg_wdata_in;
			default: next_opt_a = opt_a;
			endcase
		end
		if (topo_capture)
		begin
			// No-FET setups preload a gentle charge current under host control
			if (s_topo)
				next_charge = `CHARGE_NO_BFET;
			// Battery-only power-up skips the strap read
			next_pend_read = s_adp;
			next_pend_full = s_adp;
			next_pend_adp = s_adp;
		end
		if (system_power_monitor_rise)
		begin
			next_pend_read = 1'b1;
			next_pend_full = 1'b1;
		end
		if (adp_rise)
		begin
			next_pend_read = !strap_valid;
			next_pend_adp = 1'b1;
		end
		if (apply)
		begin
			next_adp_lim = charger_pkg::adp_limit_of(strap_band);
			if (pend_full || !system_power_monitor_on)
			begin
				next_upper = charger_pkg::upper_mv_of(strap_band);
				next_lower = charger_pkg::lower_mv_of(strap_band);
			end
			if (pend_full)
				next_opt_c[`OPT_C_HOST_BIT] = !bfet_config ||
					(charger_pkg::slot_of(strap_band) != 2'd0);
			next_pend_full = 1'b0;
			next_pend_adp = 1'b0;
			next_asg = pend_adp && s_adp;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			opt_a     <= `OPT_A_RESET;
			opt_b     <= `OPT_B_RESET;
			opt_c     <= `OPT_C_RESET;
			charge    <= '0;
			upper     <= '0;
			lower     <= '0;
			adp_lim   <= '0;
			pend_read <= 1'b0;
			pend_full <= 1'b0;
			pend_adp  <= 1'b0;
			asg       <= 1'b0;
			adp_prev  <= 1'b0;
			system_power_monitor_prev <= 1'b0;
		end
		else
		begin
			opt_a     <= next_opt_a;
			opt_b     <= next_opt_b;
			opt_c     <= next_opt_c;
			charge    <= next_charge;
			upper     <= next_upper;
			lower     <= next_lower;
			adp_lim   <= next_adp_lim;
			pend_read <= next_pend_read;
			pend_full <= next_pend_full;
			pend_adp  <= next_pend_adp;
			asg       <= next_asg;
			adp_prev  <= topo_known && s_adp;
			system_power_monitor_prev <= topo_known && system_power_monitor_on;
		end
	end

	hold_timer #(.WIDTH(16)) u_entry (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.cond_in   (entry_cond),
		.limit_in  (ENTRY_CYC),
		.done_out  (entry_done)
	);

	hold_timer #(.WIDTH(24)) u_exit (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.cond_in   (exit_cond),
		.limit_in  (exit_limit),
		.done_out  (exit_done)
	);

	hold_timer #(.WIDTH(42)) u_safety (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.cond_in   (state == charger_pkg::AUTO_CHARGE),
		.limit_in  (SAFETY_CYC),
		.done_out  (safety_done)
	);

	always_comb
	begin
		next_state = state;
		case (state)
		charger_pkg::AUTO_OFF:
			if (auto_en)
				next_state = charger_pkg::AUTO_WAIT;
		charger_pkg::AUTO_WAIT, charger_pkg::AUTO_DONE:
			if (!auto_en)
				next_state = charger_pkg::AUTO_OFF;
			else if (entry_done)
				next_state = charger_pkg::AUTO_CHARGE;
		charger_pkg::AUTO_CHARGE:
			if (!auto_en)
				next_state = charger_pkg::AUTO_OFF;
			else if (safety_done)
				next_state = charger_pkg::AUTO_EXPIRED;
			else if (exit_done)
				next_state = charger_pkg::AUTO_DONE;
		charger_pkg::AUTO_EXPIRED:
			if (!auto_en)
				next_state = charger_pkg::AUTO_OFF;
		default: next_state = charger_pkg::AUTO_OFF;
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			state <= charger_pkg::AUTO_OFF;
		else
			state <= next_state;
	end

	wire auto_chg = (state == charger_pkg::AUTO_CHARGE);
	wire bfet_next = bfet_config && !opt_c[`OPT_C_SHIP_BIT]
		&& (charge != 16'h0000 || auto_en);
	logic [15:0] rdata;

	always_comb
	begin
		case (reg_addr_in)
		`ADDR_OPT_A:   rdata = opt_a;
		`ADDR_OPT_B:   rdata = opt_b;
		`ADDR_OPT_C:   rdata = opt_c;
		`ADDR_CHARGE:  rdata = charge;
		`ADDR_UPPER:   rdata = upper;
		`ADDR_LOWER:   rdata = lower;
		`ADDR_ADP_LIM: rdata = adp_lim;
		default:       rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			reg_rdata_out           <= '0;
			adapter_switch_gate_out <= 1'b0;
			battery_fet_gate_out    <= 1'b0;
			charge_enable_out       <= 1'b0;
			charge_current_cmd_out  <= '0;
			upper_sys_voltage_out   <= '0;
			lower_sys_voltage_out   <= '0;
			adapter_limit_out       <= '0;
			switch_freq_sel_out     <= '0;
			throttle_alert_oe_n_out <= 1'b1;
			host_timeout_hold_out   <= 1'b0;
			autonomous_active_out   <= 1'b0;
		end
		else
		begin
			reg_rdata_out           <= rdata;
			adapter_switch_gate_out <= asg;
			battery_fet_gate_out    <= bfet_next;
			// Expired safety timer keeps charging off until re-enabled
			charge_enable_out <= bfet_next
				&& state != charger_pkg::AUTO_EXPIRED
				&& (auto_chg || charge != 16'h0000);
			charge_current_cmd_out  <= auto_chg ?
				`CHARGE_AUTO : charge;
			upper_sys_voltage_out   <= upper;
			lower_sys_voltage_out   <= lower;
			adapter_limit_out       <= adp_lim;
			switch_freq_sel_out     <= opt_a[`OPT_A_FREQ_LSB+:2];
			throttle_alert_oe_n_out <= !auto_chg;
			host_timeout_hold_out   <= auto_chg;
			autonomous_active_out   <= auto_chg;
		end
	end

	assign throttle_alert_out = 1'b0;

	// Low-side gate held for the minimum so zero crossing stays visible
	always_comb
	begin
		next_ls_cnt  = '0;
		next_ls_gate = lowside_request_in;
		if (lowside_gate_out)
		begin
			next_ls_cnt = (ls_cnt == LS_MIN) ? ls_cnt : ls_cnt + 5'd1;
			if (zero_cross_blocking_in && ls_cnt < LS_MIN - 5'd1)
				next_ls_gate = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ls_cnt           <= '0;
			lowside_gate_out <= 1'b0;
		end
		else
		begin
			ls_cnt           <= next_ls_cnt;
			lowside_gate_out <= next_ls_gate;
		end
	end

	assign period_stretch_out = lowside_gate_out && !lowside_request_in;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	a_ship_fet_off: assert property (opt_c[`OPT_C_SHIP_BIT]
		|=> !battery_fet_gate_out) else $error("ship bit left FET on");
	a_ship_adapter: assert property (reg_write_in
		&& reg_addr_in == `ADDR_OPT_C && s_adp && !opt_c[`OPT_C_SHIP_BIT]
		|=> !opt_c[`OPT_C_SHIP_BIT]) else $error("ship set with adapter");
	a_write_disables: assert property (reg_write_in
		&& (reg_addr_in == `ADDR_CHARGE || reg_addr_in == `ADDR_UPPER)
		&& !apply |=> opt_c[`OPT_C_HOST_BIT] ##1 !auto_chg)
		else $error("host write kept autonomous mode");
	a_auto_needs_fet: assert property (state != charger_pkg::AUTO_OFF
		|-> bfet_config && !s_topo) else $error("autonomous without FET");
	a_auto_outputs: assert property (auto_chg
		|=> !throttle_alert_oe_n_out && host_timeout_hold_out
		&& charge_current_cmd_out == `CHARGE_AUTO)
		else $error("autonomous indications wrong");
	a_strap_first: assert property ($rose(adapter_switch_gate_out)
		|-> strap_valid && $past(strap_valid, 2))
		else $error("adapter gate before strap read");
	a_freq_field: assert property (reg_write_in
		&& reg_addr_in == `ADDR_OPT_A |-> ##2
		switch_freq_sel_out == $past(reg_wdata_in[9:8], 2))
		else $error("frequency field not applied");
	a_entry_debounce: assert property (state == charger_pkg::AUTO_WAIT
		&& next_state == charger_pkg::AUTO_CHARGE
		|-> $past(entry_cond) && entry_done)
		else $error("entry without debounce");
	a_exit_cause: assert property (auto_chg
		&& next_state == charger_pkg::AUTO_DONE |-> exit_done
		&& $past(exit_cond)) else $error("exit without low current");
	a_ls_min_on: assert property (lowside_gate_out
		&& zero_cross_blocking_in && ls_cnt < LS_MIN - 5'd1
		|=> lowside_gate_out) else $error("low-side pulse too short");

	c_auto_charge: cover property (auto_chg);
	c_auto_exit: cover property (auto_chg ##1 state == charger_pkg::AUTO_DONE);
	c_ship: cover property (opt_c[`OPT_C_SHIP_BIT] && !battery_fet_gate_out);
	c_stretch: cover property (period_stretch_out);
endmodule

// ---- tb/power_stage_model.sv ----
// Analog side stand-in: adapter sense, strap decoder, battery comparators.
// Assumes the bench clock; outputs change only just after rising edges.
`timescale 1ns/10ps
module power_stage_model (
	input  wire logic       clk_in,
	input  wire logic       adapter_req_in,
	input  wire logic [4:0] band_req_in,
	input  wire logic       charging_in,
	output logic            adapter_present_out,
	output logic [4:0]      strap_band_out,
	output logic            batt_below_out,
	output logic            term_out
);
	logic [7:0] level = 8'h80;
	always @(posedge clk_in)
	begin
		adapter_present_out <= adapter_req_in;
		strap_band_out <= band_req_in;
		// Battery climbs while charged and sags otherwise
		if (charging_in && level != 8'hff)
			level <= level + 8'h01;
		else if (!charging_in && level != 8'h00)
			level <= level - 8'h01;
	end
	assign batt_below_out = (level < 8'hc0);
	assign term_out = (level == 8'hff);
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the charger mode control block.
// Assumes short timing parameters; topology pin strapped low (FET path).
`timescale 1ns/10ps
`include "charger_consts.svh"
module testbench;
	logic        clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic        reg_write_in = 1'b0;
	logic        adapter_req = 1'b0;
	logic [4:0]  band_req = 5'h02;
	logic        adapter_present, batt_below, term, charging;
	logic [4:0]  band;
	logic [15:0] rdata, cmd, upper, lower, limit;
	logic [1:0]  freq;
	logic        src_en, asw_gate, fet_gate, chg_en, alert_oe_n;
	logic        ls_req = 1'b0;
	logic        zcb = 1'b0;
	logic        ls_gate, stretch;
	int          n;
	int          num_errors = 0;
	int          num_checks = 0;
	int          i;

	always #10 clk_in = ~clk_in;
	assign charging = chg_en & fet_gate;

	power_stage_model power_stage_model_i (.clk_in(clk_in),
		.adapter_req_in(adapter_req), .band_req_in(band_req),
		.charging_in(charging), .adapter_present_out(adapter_present),
		.strap_band_out(band), .batt_below_out(batt_below),
		.term_out(term));

	charger_mode_control #(.ENTRY_CYC(16'h0014), .EXIT_SHORT_CYC(24'h00000a),
		.EXIT_LONG_CYC(24'h00001e), .SAFETY_CYC(42'h0c8))
	charger_mode_control_i (.clk_in(clk_in), .resetn_in(resetn_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_write_in(reg_write_in), .topology_select_pin_in(1'b0),
		.adapter_present_in(adapter_present),
		.batt_below_target_in(batt_below), .charge_below_term_in(term),
		.constant_voltage_loop_in(term), .strap_band_in(band),
		.lowside_request_in(ls_req), .zero_cross_blocking_in(zcb),
		.reg_rdata_out(rdata), .strap_source_en_out(src_en),
		.adapter_switch_gate_out(asw_gate), .battery_fet_gate_out(fet_gate),
		.charge_enable_out(chg_en), .charge_current_cmd_out(cmd),
		.upper_sys_voltage_out(upper), .lower_sys_voltage_out(lower),
		.adapter_limit_out(limit), .switch_freq_sel_out(freq),
		.throttle_alert_out(), .throttle_alert_oe_n_out(alert_oe_n),
		.host_timeout_hold_out(), .autonomous_active_out(),
		.lowside_gate_out(ls_gate), .period_stretch_out(stretch));

	task automatic chk(input string name, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clk_in);
		reg_write_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		tick(2);
		chk("read data", e, rdata);
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic t_regs;
		chk("alert oe_n", 16'h0001, {15'h0, alert_oe_n});
		wr(`ADDR_OPT_A, 16'h0100);
		tick(2);
		chk("freq sel", 16'h0001, {14'h0, freq});
		rd(`ADDR_OPT_A, 16'h0100);
		rd(8'h44, 16'h0000);
		rd(`ADDR_OPT_C, `OPT_C_RESET);
		$display("test regs done");
	endtask

	task automatic t_charge;
		wr(`ADDR_CHARGE, 16'h0100);
		tick(4);
		chk("fet gate", 16'h0001, {15'h0, fet_gate});
		chk("charge cmd", 16'h0100, cmd);
		rd(`ADDR_OPT_C, `OPT_C_RESET);
		$display("test charge done");
	endtask

	task automatic t_ship;
		wr(`ADDR_OPT_C, 16'h0480);
		tick(4);
		chk("ship fet", 16'h0000, {15'h0, fet_gate});
		rd(`ADDR_OPT_C, 16'h0480);
		wr(`ADDR_OPT_C, 16'h0080);
		tick(4);
		chk("ship exit fet", 16'h0001, {15'h0, fet_gate});
		$display("test ship done");
	endtask

	task automatic t_adapter;
		@(posedge clk_in);
		adapter_req <= 1'b1;
		for (i = 0; i < 20 && src_en !== 1'b1; i++)
			tick(1);
		chk("strap source", 16'h0001, {15'h0, src_en});
		chk("gate early", 16'h0000, {15'h0, asw_gate});
		for (i = 0; i < 2100 && src_en !== 1'b0; i++)
			tick(1);
		for (i = 0; i < 20 && asw_gate !== 1'b1; i++)
			tick(1);
		chk("adapter gate", 16'h0001, {15'h0, asw_gate});
		chk("adapter limit", `ILIM_LOW, limit);
		chk("upper volt", `MAX_BASE_MV, upper);
		chk("lower volt", `MIN_BASE_MV, lower);
		wr(`ADDR_OPT_C, 16'h0480);
		rd(`ADDR_OPT_C, 16'h0080);
		$display("test adapter done");
	endtask

	// One-cycle request: held to the minimum with blocking, else follows
	task automatic t_lowside;
		@(posedge clk_in);
		ls_req <= 1'b1;
		zcb <= 1'b1;
		@(posedge clk_in);
		ls_req <= 1'b0;
		#1;
		chk("stretch", 16'h0001, {15'h0, stretch});
		n = 0;
		for (i = 0; i < 40 && ls_gate === 1'b1; i++)
		begin
			n++;
			tick(1);
		end
		chk("lowside on", 16'(`LS_MIN_ON_CYC), n[15:0]);
		@(posedge clk_in);
		zcb <= 1'b0;
		ls_req <= 1'b1;
		@(posedge clk_in);
		ls_req <= 1'b0;
		tick(2);
		chk("lowside free", 16'h0000, {15'h0, ls_gate});
		$display("test lowside done");
	endtask

	initial
	begin
		tick(16);
		resetn_in <= 1'b1;
		tick(4);
		t_regs();
		t_charge();
		t_ship();
		t_adapter();
		t_lowside();
		final_report();
	end
endmodule
